/* File: rtl/eeh_host.sv */
// host-side controller driving a byte-wide parallel eeprom
//
// Behaviour
// [R1] read: select low, gate low, strobe high
// [R2] write: select low, gate high, strobe low
// [R3] select high means standby, no writes
// [R4] gate low inhibits any write
// [R5] strobe high inhibits any write
// [R6] device programs within 10 ms
// [R7] wait full program time before array access
// [R8] page byte loads 1 to 100 us apart; here a lock load after plain writes goes at once
// [R9] strobe high 1 us after lock command
// [R10] at least 10 us before next write
// [R11] polling is an ordinary read cycle
// [R12] gate may pulse between page loads
// [R13] device closes page after load window lapses
`timescale 1ns/1ps
`include "eeh_map.svh"
module eeh_host #(
    parameter int AW        = 15,
    parameter int PROG_CYC  = `EEH_PROG_CYC,
    parameter int GAP_CYC   = `EEH_NEXT_GAP_CYC
) (
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic            req_valid,
    output logic                 req_ready,
    input  wire eeh_pkg::eeh_op_t req_op,
    input  wire logic            req_last,
    input  wire logic [AW-1:0]   req_addr,
    input  wire logic [7:0]      req_wdata,
    output logic                 rsp_valid,
    output logic [7:0]           rsp_rdata,
    output logic                 busy,
    output logic [AW-1:0]        mem_addr,
    output logic                 chip_select_n,
    output logic                 output_gate_n,
    output logic                 store_strobe_n,
    input  wire logic [7:0]      data_lines_i,
    output logic [7:0]           data_lines_o,
    output logic                 data_lines_oe
);
    import eeh_pkg::*;

    localparam int CW = 22;
    localparam logic [CW-1:0] READ_CYC  = CW'(`EEH_READ_CYC);
    localparam logic [CW-1:0] PULSE_CYC = CW'(`EEH_PULSE_CYC);
    localparam logic [CW-1:0] HOLD_CYC  = CW'(`EEH_HOLD_CYC);
    localparam logic [CW-1:0] LMIN_CYC  = CW'(`EEH_LOAD_MIN_CYC);
    localparam logic [CW-1:0] LREC_CYC  = CW'(`EEH_LOCK_REC_CYC);
    localparam logic [CW-1:0] PROG_C    = CW'(PROG_CYC);
    localparam logic [CW-1:0] GAP_C     = CW'(GAP_CYC);
    // the synchroniser delays the sampled byte, so the read window is stretched
    localparam logic [CW-1:0] SYNC_LAT  = CW'(`EEH_SYNC_CYC);
    // margin so that the next strobe still falls inside the byte load window
    localparam logic [CW-1:0] LMAX_CYC  = CW'(`EEH_LOAD_MAX_CYC) - HOLD_CYC - PULSE_CYC
                                          - CW'(`EEH_LOAD_MARGIN_CYC);

    typedef struct packed {
        eeh_state_t      state;
        logic [CW-1:0]   cnt;
        logic [CW-1:0]   since;
        logic            in_page;
        logic            last;
        logic            lock;
        logic            rsp_valid;
        logic [7:0]      rdata;
        logic [AW-1:0]   addr;
        logic [7:0]      wdata;
        logic            cs_n;
        logic            oe_n;
        logic            we_n;
        logic            drive;
    } eeh_host_t;

    eeh_host_t st_r, st_nxt;
    logic [7:0] din_s;

    // pins from the device are asynchronous to sys_clk
    eeh_sync #(.W(8)) u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     (data_lines_i),
        .dout    (din_s)
    );

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        return (&v) ? v : v + CW'(1);
    endfunction

    // a countdown has run out
    function automatic logic expired(input logic [CW-1:0] v);
        return v == '0;
    endfunction

    // after a last byte, or when the device closes a page by itself, the host
    // must sit out the whole program time
    function automatic eeh_host_t begin_prog(input eeh_host_t s);
        eeh_host_t r;
        r         = s;
        r.in_page = 1'b0;
        r.lock    = 1'b0;
        r.cnt     = PROG_C;
        r.state   = EEH_PROG;
        return r;
    endfunction

    // the next page load may only go once the minimum spacing has passed, except a lock load into a page of plain writes, which goes at once
    logic load_ok;
    assign load_ok = st_r.since >= (st_r.lock ? LREC_CYC : LMIN_CYC); // [R8] [R9]

    // the device closes a page left idle past the load window and starts
    // programming; the host follows so that it never touches the array early
    logic lapsed;
    assign lapsed = st_r.in_page && (st_r.since >= LMAX_CYC); // [R7] [R8]

    always_comb begin
        st_nxt           = st_r;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.since     = sat_inc(st_r.since);
        st_nxt.cnt       = !expired(st_r.cnt) ? st_r.cnt - CW'(1) : '0;
        req_ready        = 1'b0;
        unique case (st_r.state)
            EEH_IDLE: begin
                // a page left open must be continued with the next write or read
                // nothing is taken in the cycle in which a lapsed page is closed
                req_ready = !lapsed && (!st_r.in_page || load_ok
                            || (req_op != EEH_OP_WRITE && !st_r.lock));
                if (req_valid && req_ready) begin
                    st_nxt.addr = req_addr;
                    st_nxt.wdata = req_wdata;
                    st_nxt.last = req_last;
                    st_nxt.cs_n = 1'b0;
                    if (req_op == EEH_OP_READ) begin
                        st_nxt.oe_n  = 1'b0; // [R1] [R11] [R12]
                        st_nxt.cnt   = READ_CYC + SYNC_LAT; // [R11]
                        st_nxt.state = EEH_RD;
                    end else begin
                        st_nxt.oe_n  = 1'b1; // [R4]
                        st_nxt.we_n  = 1'b0; // [R2]
                        st_nxt.drive = 1'b1;
                        st_nxt.lock  = (req_op == EEH_OP_LOCK);
                        st_nxt.cnt   = PULSE_CYC;
                        st_nxt.state = EEH_WR;
                    end
                end
                if (lapsed) begin
                    st_nxt = begin_prog(st_nxt); // [R7]
                end
            end
            EEH_RD: begin
                if (expired(st_r.cnt)) begin
                    st_nxt.rdata     = din_s;
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.cs_n      = 1'b1;
                    st_nxt.oe_n      = 1'b1;
                    st_nxt.state     = EEH_IDLE;
                end
            end
            EEH_WR: begin
                if (expired(st_r.cnt)) begin
                    st_nxt.we_n  = 1'b1; // [R5]
                    st_nxt.cnt   = HOLD_CYC;
                    st_nxt.state = EEH_HOLD;
                end
            end
            EEH_HOLD: begin
                // address and data held past the strobe edge, then deselect
                if (expired(st_r.cnt)) begin
                    st_nxt.cs_n    = 1'b1; // [R3]
                    st_nxt.drive   = 1'b0;
                    st_nxt.since   = '0;
                    st_nxt.in_page = !st_r.last;
                    if (st_r.last) begin
                        st_nxt = begin_prog(st_nxt); // [R7]
                    end else begin
                        st_nxt.state = EEH_IDLE;
                    end
                end
            end
            EEH_PROG: begin
                // no polling here: the full program time is always waited out
                if (expired(st_r.cnt)) begin // [R6] [R7]
                    st_nxt.cnt   = GAP_C;
                    st_nxt.state = EEH_GAP;
                end
            end
            EEH_GAP: begin
                if (expired(st_r.cnt)) begin // [R10]
                    st_nxt.state = EEH_IDLE;
                end
            end
            default: begin
                st_nxt.state = EEH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r       <= '0;
            st_r.state <= EEH_IDLE;
            st_r.cs_n  <= 1'b1;
            st_r.oe_n  <= 1'b1;
            st_r.we_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp_valid      = st_r.rsp_valid;
    assign rsp_rdata      = st_r.rdata;
    assign busy           = st_r.state != EEH_IDLE;
    assign mem_addr       = st_r.addr;
    assign chip_select_n  = st_r.cs_n;
    assign output_gate_n  = st_r.oe_n;
    assign store_strobe_n = st_r.we_n;
    assign data_lines_o   = st_r.wdata;
    assign data_lines_oe  = st_r.drive;
endmodule // eeh_host

/* File: rtl/eeh_map.svh */
// timing counts and constants for the eeprom host controller
`ifndef EEH_MAP_SVH
`define EEH_MAP_SVH
`define EEH_CLK_MHZ            40
`define EEH_PROG_TIME_MS       10
`define EEH_PROG_CYC           (`EEH_PROG_TIME_MS * 1000 * `EEH_CLK_MHZ)
`define EEH_LOAD_MIN_US        1
`define EEH_LOAD_MIN_CYC       (`EEH_LOAD_MIN_US * `EEH_CLK_MHZ)
`define EEH_LOAD_MAX_US        100
`define EEH_LOAD_MAX_CYC       (`EEH_LOAD_MAX_US * `EEH_CLK_MHZ)
`define EEH_LOAD_MARGIN_CYC    4
`define EEH_SYNC_CYC           3
`define EEH_LOCK_REC_US        1
`define EEH_LOCK_REC_CYC       (`EEH_LOCK_REC_US * `EEH_CLK_MHZ)
`define EEH_NEXT_GAP_US        10
`define EEH_NEXT_GAP_CYC       (`EEH_NEXT_GAP_US * `EEH_CLK_MHZ)
`define EEH_READ_NS            300
`define EEH_READ_CYC           ((`EEH_READ_NS + 24) / 25)
`define EEH_PULSE_NS           100
`define EEH_PULSE_CYC          ((`EEH_PULSE_NS + 24) / 25)
`define EEH_HOLD_NS            150
`define EEH_HOLD_CYC           ((`EEH_HOLD_NS + 24) / 25)
`endif

/* File: rtl/eeh_pkg.sv */
// types for the eeprom host controller
package eeh_pkg;
    typedef enum logic [2:0] {
        EEH_IDLE  = 3'b000,
        EEH_RD    = 3'b001,
        EEH_WR    = 3'b010,
        EEH_HOLD  = 3'b011,
        EEH_GAP   = 3'b100,
        EEH_PROG  = 3'b101
    } eeh_state_t;
    typedef enum logic [1:0] {
        EEH_OP_READ  = 2'b00,
        EEH_OP_WRITE = 2'b01,
        EEH_OP_LOCK  = 2'b10
    } eeh_op_t;
endpackage

/* File: rtl/eeh_sync.sv */
// three-stage input synchroniser, change taken when the last two agree
`timescale 1ns/1ps
module eeh_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import eeh_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } eeh_sync_t;
    eeh_sync_t st_r, st_nxt;
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign dout = st_r.q;
endmodule // eeh_sync

/* File: tb/eeh_host_monitor.sv */
// pin assertions for the eeprom host controller
`timescale 1ns/1ps
module eeh_host_monitor #(parameter int PROG_CYC = 50) (
    input logic sys_clk,
    input logic reset,
    input logic req_valid,
    input logic req_ready,
    input eeh_pkg::eeh_op_t req_op,
    input logic req_last,
    input logic rsp_valid,
    input logic busy,
    input logic chip_select_n,
    input logic output_gate_n,
    input logic store_strobe_n,
    input logic data_lines_oe
);
    import eeh_pkg::*;
    logic [15:0] hi_r;
    logic [31:0] pc_r;
    wire tk_w = req_valid && req_ready && req_last && req_op != EEH_OP_READ;
    // saturates so the first load after reset is not taken as too close
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hi_r <= 16'hFFFF;
            pc_r <= 32'h0;
        end else begin
            hi_r <= store_strobe_n ? hi_r + 16'(hi_r != 16'hFFFF) : 16'h0;
            pc_r <= tk_w ? 32'(PROG_CYC + 12) : pc_r - 32'(pc_r != 0);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    bus_free_a: assert property (!output_gate_n |-> !data_lines_oe)
        else $error("host drives data in read");
    rd_mode_a: assert property (!output_gate_n |-> !chip_select_n && store_strobe_n)
        else $error("bad read strobes");
    wr_mode_a: assert property (!store_strobe_n |-> !chip_select_n && output_gate_n)
        else $error("bad write strobes");
    idle_pins_a: assert property (chip_select_n |-> store_strobe_n && output_gate_n)
        else $error("strobe while deselected");
    wr_pulse_a: assert property ($fell(store_strobe_n) |-> !store_strobe_n [*5] ##1 store_strobe_n)
        else $error("bad strobe width");
    load_gap_a: assert property ($fell(store_strobe_n) |-> hi_r >= 16'd40)
        else $error("byte loads too close");
    prog_wait_a: assert property (pc_r != 0 |-> busy && !req_ready)
        else $error("program wait cut short");
    rsp_read_a: assert property (rsp_valid |-> !$past(output_gate_n) && !$past(rsp_valid))
        else $error("answer without read");
endmodule // eeh_host_monitor
bind eeh_host eeh_host_monitor #(.PROG_CYC(PROG_CYC)) u_mon (.*);

/* File: tb/eeh_host_tb.sv */
// bench: host controller against a behavioural eeprom and a reference array
`timescale 1ns/1ps
module eeh_host_tb;
    import eeh_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_last = 1'b0;
    eeh_op_t req_op = EEH_OP_READ;
    logic [14:0] req_addr = 15'h0, mem_addr;
    logic [7:0] req_wdata = 8'h00, rsp_rdata, data_lines_i, data_lines_o;
    logic req_ready, rsp_valid, busy, chip_select_n, output_gate_n, store_strobe_n;
    logic data_lines_oe;
    logic [7:0] ref_mem [int];
    int n_errors = 0, samples_checked = 0, n;
    always #12.5 sys_clk = ~sys_clk;
    // program time cut to 50 cycles so programming ends quickly
    eeh_host #(.PROG_CYC(50), .GAP_CYC(10)) i_dut (.*);
    eeh_mem_model #(.PROG_NS(1250.0)) i_mem (.*);
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic fail(string m, bit stop);
        n_errors++;
        $display("mismatch at %0t: %s", $time, m);
        if (stop)
            end_sim();
    endtask
    task automatic check_rd(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
            fail("read data", 1'b0);
    endtask
    task automatic check_busy(logic got, logic exp);
        samples_checked++;
        if (got !== exp)
            fail("busy state", 1'b0);
    endtask
    // reads sent with chk set are checked against the reference array once the answer arrives
    task automatic send(eeh_op_t op, logic l, logic [14:0] ad, logic [7:0] d, bit chk = 1'b1);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_op = op;
        req_last = l;
        req_addr = ad;
        req_wdata = d;
        if (op != EEH_OP_READ)
            ref_mem[ad] = d;
        // ready depends on the new opcode, so let it settle before looking
        #1;
        for (n = 0; n < 500 && req_ready !== 1'b1; n++)
            @(negedge sys_clk);
        if (n == 500)
            fail("request not taken", 1'b1);
        @(negedge sys_clk);
        req_valid = 1'b0;
        if (op == EEH_OP_READ) begin
            for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
                @(negedge sys_clk);
            if (n == 40)
                fail("read not answered", 1'b1);
            if (chk)
                check_rd(rsp_rdata, ref_mem[ad]);
        end
    endtask
    initial begin
        void'($urandom(97976));
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        for (int i = 0; i < 16; i++) begin
            send(EEH_OP_WRITE, i == 15, 15'(i), 8'($urandom));
            if (i == 7)
                send(EEH_OP_READ, 1'b0, 15'h0000, 8'h00, 1'b0);
        end
        for (int i = 0; i < 16; i++)
            send(EEH_OP_READ, 1'b0, 15'(i), 8'h00);
        $display("test page done");
        for (int i = 0; i < 3; i++)
            send(EEH_OP_LOCK, 1'b0, 15'(32 + i), 8'($urandom));
        send(EEH_OP_WRITE, 1'b1, 15'h7FFF, 8'hA5);
        send(EEH_OP_READ, 1'b0, 15'h7FFF, 8'h00);
        $display("test lock done");
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        check_busy(busy, 1'b0);
        $display("test reset done");
        // a page left open past the load window must be closed and waited out
        send(EEH_OP_WRITE, 1'b0, 15'h0028, 8'($urandom));
        repeat (3000) @(negedge sys_clk);
        check_busy(busy, 1'b0);
        for (n = 0; n < 1200 && busy !== 1'b1; n++)
            @(negedge sys_clk);
        if (n == 1200)
            fail("page never closed", 1'b1);
        check_busy(busy, 1'b1);
        send(EEH_OP_READ, 1'b0, 15'h0028, 8'h00);
        $display("test lapse done");
        // a read straight after a write shows whether the program wait was kept
        for (int i = 0; i < 40; i++) begin
            if ($urandom % 2)
                send(EEH_OP_WRITE, 1'b1, 15'($urandom % 16), 8'($urandom));
            else
                send(EEH_OP_READ, 1'b0, 15'($urandom % 16), 8'h00);
        end
        $display("test random done");
        end_sim();
    end
endmodule // eeh_host_tb

/* File: tb/eeh_mem_model.sv */
// behavioural byte-wide eeprom answering the host controller
`timescale 1ns/1ps
module eeh_mem_model #(parameter real PROG_NS = 1250.0) (
    input logic [14:0] mem_addr,
    input logic chip_select_n,
    input logic output_gate_n,
    input logic store_strobe_n,
    input logic [7:0] data_lines_o,
    input logic data_lines_oe,
    output logic [7:0] data_lines_i
);
    logic [7:0] mem [0:32767];
    realtime t_ld = -1.0e6;
    initial data_lines_i = 8'h00;
    // timed from the latest load, so further loads keep the page open
    always @(posedge store_strobe_n) begin
        if (!chip_select_n && output_gate_n) begin
            mem[mem_addr] = data_lines_o;
            t_ld = $realtime;
        end
    end
    // a released bus shows the complement, never a held byte
    always @(chip_select_n, output_gate_n, store_strobe_n, mem_addr, data_lines_o,
             data_lines_oe) begin
        if (data_lines_oe)
            data_lines_i = data_lines_o;
        else if (!chip_select_n && !output_gate_n && store_strobe_n)
            data_lines_i = ($realtime - t_ld < PROG_NS) ? ~mem[mem_addr] : mem[mem_addr];
        else
            data_lines_i = ~data_lines_i;
    end
endmodule // eeh_mem_model
